//--- lsdc_pkg.sv
// Constants and types shared by the load switch driver control block.
// Assumes one 50 MHz clock domain and a host that writes control fields.
`default_nettype none

package lsdc_pkg;

    // High-side control write data field positions
    localparam int HS_ON_BIT      = 0;
    localparam int HS_PWM_SEL_BIT = 2;

    // Low-side control write data field positions
    localparam int LS1_ON_BIT      = 0;
    localparam int LS2_ON_BIT      = 1;
    localparam int LS1_PWM_SEL_BIT = 2;
    localparam int LS2_PWM_SEL_BIT = 3;

    // Control field width and value after reset
    localparam int         CTRL_W   = 4;
    localparam logic [3:0] CTRL_RST = 4'h0;

    // Interrupt source codes
    localparam logic [3:0] ISRC_NONE = 4'h0;
    localparam logic [3:0] ISRC_HS   = 4'h2;
    localparam logic [3:0] ISRC_LS   = 4'h3;

    // Synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 2;

    // Analog sense inputs of the high-side switch
    typedef struct packed {
        logic overtemp;
        logic open_load;
        logic cur_limit;
    } lsdc_hs_sense_type;

    // Analog sense inputs of the two low-side switches
    typedef struct packed {
        logic overtemp;
        logic ls2_open_load;
        logic ls2_cur_limit;
        logic ls1_open_load;
        logic ls1_cur_limit;
    } lsdc_ls_sense_type;

    // High-side status field, bit 1 open load, bit 0 current limit
    typedef struct packed {
        logic hs_open_load_flag;
        logic hs_current_limit_flag;
    } lsdc_hs_status_type;

    // Low-side status field, bits 3..0
    typedef struct packed {
        logic ls2_open_load_flag;
        logic ls2_current_limit_flag;
        logic ls1_open_load_flag;
        logic ls1_current_limit_flag;
    } lsdc_ls_status_type;

    // Interrupt mask bits
    typedef struct packed {
        logic hs_irq_enable;
        logic ls_irq_enable;
    } lsdc_irq_mask_type;

    // Drive mode of one switch
    typedef enum logic [1:0] {
        DRV_OFF,
        DRV_ON,
        DRV_PWM,
        DRV_SHUT
    } lsdc_drv_type;

endpackage

`default_nettype wire

//--- lsdc_sync.sv
// Bank of two-stage synchronisers for asynchronous pin inputs.
// Assumes each bit is an independent level; no bus coherency is given.
`timescale 1ns/1ns
`default_nettype none

module lsdc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rstn,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    import lsdc_pkg::*;

    logic [WIDTH-1:0] meta_q;

    // First stage, read only by the second stage
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_q <= '0;
        end else begin
            meta_q <= i_async;
        end
    end

    // Second stage feeds the block logic
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sync <= '0;
        end else begin
            o_sync <= meta_q;
        end
    end

endmodule

`default_nettype wire

//--- lsdc_switch_ctrl.sv
// Control and protection logic for one high-side and two low-side switches.
// Assumes control writes arrive as one-cycle strobes on i_mclk and that
// sense, supply and PWM pins are asynchronous levels from the analog side.
//
// Operation
// - High-side output follows its switch-on control bit.
// - With switch-on and PWM select set, high-side output follows the PWM pin.
// - High-side open-load flag set while load current is below threshold.
// - High-side current-limit flag set while output is current limited.
// - High-side overtemperature turns output off, latches, reports source.
// - High-side thermal shutdown shows both status flags set together.
// - High-side thermal latch raises interrupt only when its mask enables.
// - High-side thermal latch clears on control write once heat is gone.
// - Overvoltage with shutdown enabled turns high-side output off.
// - High-side overvoltage latch clears on control write once cleared.
// - High-side output may stay enabled in sleep and stop modes.
// - Each low-side output follows its own switch-on bit.
// - Low-side output with switch-on and PWM select set follows the PWM pin.
// - Low-side open-load flags set while current is below threshold.
// - Low-side current-limit flags set while output is current limited.
// - Low-side overtemperature turns both off, latches, reports source.
// - Low-side thermal latch raises interrupt only when its mask enables.
// - Low-side thermal latch clears on control write once heat is gone.
// - Overvoltage with shutdown enabled turns both low-side outputs off.
// - Low-side overvoltage latch clears on control write once cleared.
// - Low-side outputs held off in sleep or stop mode.
// - High-side thermal interrupt source code is 0010.
// - Low-side thermal interrupt source code is 0011.
// - High-side write data: PWM select bit 2, switch-on bit 0.
// - Low-side write data: PWM2 bit 3, PWM1 bit 2, LS2 1, LS1 0.
`timescale 1ns/1ns
`default_nettype none

module lsdc_switch_ctrl (
    input  wire logic                        i_mclk,
    input  wire logic                        i_rstn,
    input  wire logic                        i_hs_ctrl_wr,
    input  wire logic [3:0]                  i_hs_ctrl_data,
    input  wire logic                        i_ls_ctrl_wr,
    input  wire logic [3:0]                  i_ls_ctrl_data,
    input  wire logic                        i_overvoltage_shutdown_enable,
    input  wire lsdc_pkg::lsdc_irq_mask_type i_irq_mask,
    input  wire logic                        i_low_power_mode,
    input  wire logic                        i_pwm_direct_input,
    input  wire logic                        i_high_voltage,
    input  wire lsdc_pkg::lsdc_hs_sense_type i_hs_sense,
    input  wire lsdc_pkg::lsdc_ls_sense_type i_ls_sense,
    output logic                             o_hs_on,
    output logic                             o_ls1_on,
    output logic                             o_ls2_on,
    output lsdc_pkg::lsdc_hs_status_type     o_hs_status,
    output lsdc_pkg::lsdc_ls_status_type     o_ls_status,
    output logic [3:0]                       o_irq_source,
    output logic                             o_irq_n
);
    import lsdc_pkg::*;

    // Width of the synchronised pin bundle
    localparam int PIN_W = 10;

    // Synchronised pin levels
    logic [PIN_W-1:0]  pins_async;
    logic [PIN_W-1:0]  pins_sync;
    logic              pwm_s;
    logic              hv_s;
    lsdc_hs_sense_type hs_sense_s;
    lsdc_ls_sense_type ls_sense_s;

    // Stored control fields
    logic [CTRL_W-1:0] hs_ctrl_q;
    logic [CTRL_W-1:0] ls_ctrl_q;

    // Shutdown latches
    logic hs_ot_q;
    logic hs_hv_q;
    logic ls_ot_q;
    logic ls_hv_q;

    // Latch set and clear terms
    logic hs_ot_set;
    logic hs_ot_clr;
    logic hs_hv_set;
    logic hs_hv_clr;
    logic ls_ot_set;
    logic ls_ot_clr;
    logic ls_hv_set;
    logic ls_hv_clr;

    // Blocking terms and drive modes
    logic         hs_block;
    logic         ls_block;
    lsdc_drv_type hs_mode;
    lsdc_drv_type ls1_mode;
    lsdc_drv_type ls2_mode;
    logic         hs_on_d;
    logic         ls1_on_d;
    logic         ls2_on_d;

    // Interrupt pending terms
    logic hs_pend;
    logic ls_pend;

    // Mode of one switch from its control bits and shutdown state
    // Shutdown outranks every control setting, so a stray write can
    // never switch a blocked output back on.
    function automatic lsdc_drv_type drv_mode(input logic on,
                                              input logic pwm_sel,
                                              input logic blocked);
        lsdc_drv_type m;
        m = DRV_OFF;
        if (blocked) begin
            m = DRV_SHUT;
        end else if (on && pwm_sel) begin
            m = DRV_PWM;
        end else if (on) begin
            m = DRV_ON;
        end
        return m;
    endfunction

    // Output level for a drive mode and the current PWM level
    // Only the synchronised PWM level comes in here; the raw pin would
    // let a metastable level reach the output flop.
    function automatic logic drv_level(input lsdc_drv_type m,
                                       input logic pwm);
        logic lvl;
        lvl = 1'b0;
        case (m)
            DRV_ON:   lvl = 1'b1;
            DRV_PWM:  lvl = pwm;
            DRV_OFF:  lvl = 1'b0;
            DRV_SHUT: lvl = 1'b0;
            default:  lvl = 1'b0;
        endcase
        return lvl;
    endfunction

    // Every pin level is asynchronous to i_mclk
    // Limitation: a level shorter than one clock may be missed, and
    // each pin takes two edges before the logic sees it.
    assign pins_async = {i_pwm_direct_input, i_high_voltage,
                         i_hs_sense, i_ls_sense};

    lsdc_sync #(
        .WIDTH (PIN_W)
    ) u_pin_sync (
        .i_mclk  (i_mclk),
        .i_rstn  (i_rstn),
        .i_async (pins_async),
        .o_sync  (pins_sync)
    );

    // Unpack the synchronised bundle
    assign pwm_s      = pins_sync[9];
    assign hv_s       = pins_sync[8];
    assign hs_sense_s = pins_sync[7:5];
    assign ls_sense_s = pins_sync[4:0];

    // High-side control field, reserved bits 3 and 1 kept at zero
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            hs_ctrl_q <= CTRL_RST;
        end else if (i_hs_ctrl_wr) begin
            hs_ctrl_q                 <= CTRL_RST;
            hs_ctrl_q[HS_ON_BIT]      <= i_hs_ctrl_data[HS_ON_BIT];
            hs_ctrl_q[HS_PWM_SEL_BIT] <= i_hs_ctrl_data[HS_PWM_SEL_BIT];
        end
    end

    // Low-side control field, all four bits used
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ls_ctrl_q <= CTRL_RST;
        end else if (i_ls_ctrl_wr) begin
            ls_ctrl_q <= i_ls_ctrl_data;
        end
    end

    // Latch set and clear terms; a clear needs the fault already gone
    // Set and clear read the same synchronised copy of the fault, so
    // they never disagree about its level.
    assign hs_ot_set = hs_sense_s.overtemp;
    assign hs_ot_clr = i_hs_ctrl_wr && !hs_sense_s.overtemp;
    assign hs_hv_set = hv_s && i_overvoltage_shutdown_enable;
    assign hs_hv_clr = i_hs_ctrl_wr && !hv_s;
    assign ls_ot_set = ls_sense_s.overtemp;
    assign ls_ot_clr = i_ls_ctrl_wr && !ls_sense_s.overtemp;
    assign ls_hv_set = hv_s && i_overvoltage_shutdown_enable;
    assign ls_hv_clr = i_ls_ctrl_wr && !hv_s;

    // High-side thermal latch, set wins over clear
    // A write that lands while still hot leaves the latch set; the
    // host must write again once the fault has gone.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            hs_ot_q <= 1'b0;
        end else if (hs_ot_set) begin
            hs_ot_q <= 1'b1;
        end else if (hs_ot_clr) begin
            hs_ot_q <= 1'b0;
        end
    end

    // High-side overvoltage latch, set wins over clear
    // Both sides share the supply pin but keep their own latches, so
    // each side is re-armed only by its own control write.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            hs_hv_q <= 1'b0;
        end else if (hs_hv_set) begin
            hs_hv_q <= 1'b1;
        end else if (hs_hv_clr) begin
            hs_hv_q <= 1'b0;
        end
    end

    // Low-side thermal latch, shared by both switches
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ls_ot_q <= 1'b0;
        end else if (ls_ot_set) begin
            ls_ot_q <= 1'b1;
        end else if (ls_ot_clr) begin
            ls_ot_q <= 1'b0;
        end
    end

    // Low-side overvoltage latch, shared by both switches
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ls_hv_q <= 1'b0;
        end else if (ls_hv_set) begin
            ls_hv_q <= 1'b1;
        end else if (ls_hv_clr) begin
            ls_hv_q <= 1'b0;
        end
    end

    // Blocking includes the set term, so the output drops in the same
    // edge the latch sets instead of one cycle later.
    // Low-power mode is left out of the high-side term on purpose:
    // the high side may keep powering periodic sensing.
    assign hs_block = hs_ot_q || hs_ot_set
                   || hs_hv_q || hs_hv_set;
    assign ls_block = ls_ot_q || ls_ot_set
                   || ls_hv_q || ls_hv_set
                   || i_low_power_mode;

    // Drive modes of the three switches
    assign hs_mode  = drv_mode(hs_ctrl_q[HS_ON_BIT],
                               hs_ctrl_q[HS_PWM_SEL_BIT],
                               hs_block);
    assign ls1_mode = drv_mode(ls_ctrl_q[LS1_ON_BIT],
                               ls_ctrl_q[LS1_PWM_SEL_BIT],
                               ls_block);
    assign ls2_mode = drv_mode(ls_ctrl_q[LS2_ON_BIT],
                               ls_ctrl_q[LS2_PWM_SEL_BIT],
                               ls_block);

    // Output levels, PWM taken only from the synchronised pin
    assign hs_on_d  = drv_level(hs_mode, pwm_s);
    assign ls1_on_d = drv_level(ls1_mode, pwm_s);
    assign ls2_on_d = drv_level(ls2_mode, pwm_s);

    // Registered switch outputs
    // One cycle of latency is traded for drive pins free of glitches
    // from the decode logic.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_hs_on  <= 1'b0;
            o_ls1_on <= 1'b0;
            o_ls2_on <= 1'b0;
        end else begin
            o_hs_on  <= hs_on_d;
            o_ls1_on <= ls1_on_d;
            o_ls2_on <= ls2_on_d;
        end
    end

    // High-side status; a thermal shutdown forces both flags high
    // Flags are live, not sticky; only the thermal case is held, and
    // that by the shutdown latch rather than by the flags.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_hs_status <= '0;
        end else begin
            o_hs_status.hs_open_load_flag <=
                hs_sense_s.open_load || hs_ot_q;
            o_hs_status.hs_current_limit_flag <=
                hs_sense_s.cur_limit || hs_ot_q;
        end
    end

    // Low-side status; a thermal shutdown sets all four flags
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ls_status <= '0;
        end else begin
            o_ls_status.ls1_open_load_flag <=
                ls_sense_s.ls1_open_load || ls_ot_q;
            o_ls_status.ls2_open_load_flag <=
                ls_sense_s.ls2_open_load || ls_ot_q;
            o_ls_status.ls1_current_limit_flag <=
                ls_sense_s.ls1_cur_limit || ls_ot_q;
            o_ls_status.ls2_current_limit_flag <=
                ls_sense_s.ls2_cur_limit || ls_ot_q;
        end
    end

    // A masked event neither shows a source nor pulls the request
    // Trade-off: unmasking later reveals a latch that may be old, as
    // the latch itself keeps no record of when it was set.
    assign hs_pend = hs_ot_q && i_irq_mask.hs_irq_enable;
    assign ls_pend = ls_ot_q && i_irq_mask.ls_irq_enable;

    // Source code; high side reported first when both are pending
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_irq_source <= ISRC_NONE;
        end else if (hs_pend) begin
            o_irq_source <= ISRC_HS;
        end else if (ls_pend) begin
            o_irq_source <= ISRC_LS;
        end else begin
            o_irq_source <= ISRC_NONE;
        end
    end

    // Active-low request, held while any enabled thermal latch is set
    // Released when a control write clears the latch behind it or its mask bit drops.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_irq_n <= 1'b1;
        end else begin
            o_irq_n <= !(hs_pend || ls_pend);
        end
    end

endmodule

`default_nettype wire

//--- lsdc_props.sv
// Output relations of the switch control block, checked at its ports.
// Assumes the package constants and one clock; bound to the design below.
`timescale 1ns/1ns
`default_nettype none

module lsdc_props (
    input wire logic                        i_mclk,
    input wire logic                        i_rstn,
    input wire logic                        i_hs_ctrl_wr,
    input wire logic [3:0]                  i_hs_ctrl_data,
    input wire logic                        i_ls_ctrl_wr,
    input wire logic [3:0]                  i_ls_ctrl_data,
    input wire logic                        i_overvoltage_shutdown_enable,
    input wire lsdc_pkg::lsdc_irq_mask_type i_irq_mask,
    input wire logic                        i_low_power_mode,
    input wire logic                        i_high_voltage,
    input wire lsdc_pkg::lsdc_hs_sense_type i_hs_sense,
    input wire lsdc_pkg::lsdc_ls_sense_type i_ls_sense,
    input wire logic                        o_hs_on,
    input wire logic                        o_ls1_on,
    input wire logic                        o_ls2_on,
    input wire lsdc_pkg::lsdc_hs_status_type o_hs_status,
    input wire logic [3:0]                  o_irq_source,
    input wire logic                        o_irq_n
);
    import lsdc_pkg::*;
    logic [3:0] hs_fld_q;
    logic [3:0] ls_fld_q;

    // Shadow copies of the stored control fields, same edge as the design
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            hs_fld_q <= 4'h0;
            ls_fld_q <= 4'h0;
        end else begin
            if (i_hs_ctrl_wr) hs_fld_q <= i_hs_ctrl_data;
            if (i_ls_ctrl_wr) ls_fld_q <= i_ls_ctrl_data;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    // Faults held long enough to pass the two-flop synchronisers
    sequence s_hs_hot; i_hs_sense.overtemp [*4]; endsequence
    sequence s_ls_hot; i_ls_sense.overtemp [*4]; endsequence
    sequence s_hv_cut;
        (i_high_voltage && i_overvoltage_shutdown_enable) [*4];
    endsequence

    property p_hs_off; (hs_fld_q[0] == 1'b0) [*3] |-> !o_hs_on; endproperty
    property p_ls1_off;
        (ls_fld_q[0] == 1'b0) [*3] |-> !o_ls1_on;
    endproperty
    property p_hs_hot; s_hs_hot |-> !o_hs_on; endproperty
    property p_hs_flags; s_hs_hot |=> o_hs_status == 2'h3; endproperty
    property p_hs_irq;
        (i_hs_sense.overtemp && i_irq_mask.hs_irq_enable) [*4]
            |=> o_irq_source == ISRC_HS && !o_irq_n;
    endproperty
    property p_ls_irq;
        (i_ls_sense.overtemp && i_irq_mask.ls_irq_enable
            && !i_irq_mask.hs_irq_enable) [*4]
            |=> o_irq_source == ISRC_LS && !o_irq_n;
    endproperty
    property p_ls_hot; s_ls_hot |-> !o_ls1_on && !o_ls2_on; endproperty
    property p_masked;
        (!i_irq_mask.hs_irq_enable && !i_irq_mask.ls_irq_enable) [*2]
            |-> o_irq_n && o_irq_source == ISRC_NONE;
    endproperty
    property p_sleep;
        i_low_power_mode [*2] |-> !o_ls1_on && !o_ls2_on;
    endproperty
    property p_hv;
        s_hv_cut |-> !o_hs_on && !o_ls1_on && !o_ls2_on;
    endproperty
    property p_open;
        i_hs_sense.open_load [*4] |-> o_hs_status.hs_open_load_flag;
    endproperty

    a_hs_off: assert property (p_hs_off) else $error("hs on, bit off");
    a_ls1_off: assert property (p_ls1_off) else $error("ls1 on");
    a_hs_hot: assert property (p_hs_hot) else $error("hs on while hot");
    a_hs_flags: assert property (p_hs_flags) else $error("hs flags");
    a_hs_irq: assert property (p_hs_irq) else $error("hs irq code");
    a_ls_irq: assert property (p_ls_irq) else $error("ls irq code");
    a_ls_hot: assert property (p_ls_hot) else $error("ls on while hot");
    a_masked: assert property (p_masked) else $error("masked irq");
    a_sleep: assert property (p_sleep) else $error("ls on in sleep");
    a_hv: assert property (p_hv) else $error("on at high volt");
    a_open: assert property (p_open) else $error("open load flag");
endmodule

bind lsdc_switch_ctrl lsdc_props i_lsdc_props (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_hs_ctrl_wr(i_hs_ctrl_wr),
    .i_hs_ctrl_data(i_hs_ctrl_data), .i_ls_ctrl_wr(i_ls_ctrl_wr),
    .i_ls_ctrl_data(i_ls_ctrl_data), .i_irq_mask(i_irq_mask),
    .i_overvoltage_shutdown_enable(i_overvoltage_shutdown_enable),
    .i_low_power_mode(i_low_power_mode), .i_high_voltage(i_high_voltage),
    .i_hs_sense(i_hs_sense), .i_ls_sense(i_ls_sense), .o_hs_on(o_hs_on),
    .o_ls1_on(o_ls1_on), .o_ls2_on(o_ls2_on), .o_hs_status(o_hs_status),
    .o_irq_source(o_irq_source), .o_irq_n(o_irq_n)
);

`default_nettype wire

//--- lsdc_host.sv
// Host model: control writes and the direct PWM pin of the switch block.
// Assumes the bench calls its tasks; all changes land on falling edges.
`timescale 1ns/1ns
`default_nettype none

module lsdc_host (
    input  wire logic       i_mclk,
    output logic            o_hs_wr,
    output logic [3:0]      o_hs_data,
    output logic            o_ls_wr,
    output logic [3:0]      o_ls_data,
    output logic            o_pwm
);
    // Idle values from time zero
    initial begin
        o_hs_wr = 1'h0;
        o_hs_data = 4'h0;
        o_ls_wr = 1'h0;
        o_ls_data = 4'h0;
        o_pwm = 1'h0;
    end

    // One-cycle strobe; data scrambled after so stale values never help
    task automatic wr_hs(input logic [3:0] d);
        @(negedge i_mclk);
        o_hs_wr <= 1'h1;
        o_hs_data <= d;
        @(negedge i_mclk);
        o_hs_wr <= 1'h0;
        o_hs_data <= ~d;
    endtask

    task automatic wr_ls(input logic [3:0] d);
        @(negedge i_mclk);
        o_ls_wr <= 1'h1;
        o_ls_data <= d;
        @(negedge i_mclk);
        o_ls_wr <= 1'h0;
        o_ls_data <= ~d;
    endtask

    task automatic set_pwm(input logic v);
        @(negedge i_mclk);
        o_pwm <= v;
    endtask
endmodule

`default_nettype wire

//--- lsdc_switch_ctrl_tb.sv
// Self-checking bench for the switch control block.
// Assumes the host model drives writes and PWM; faults come from here.
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end

module lsdc_switch_ctrl_tb;
    import lsdc_pkg::*;
    logic               mclk;
    logic               rstn;
    logic               hs_wr, ls_wr, pwm, hs_on, ls1_on, ls2_on, irq_n;
    logic [3:0]         hs_data, ls_data, irq_source;
    logic               ov_en;
    logic               lpm;
    logic               hv;
    lsdc_irq_mask_type  irq_mask;
    lsdc_hs_sense_type  hs_sense;
    lsdc_ls_sense_type  ls_sense;
    lsdc_hs_status_type hs_status;
    lsdc_ls_status_type ls_status;
    int                 n_errors = 0;
    int                 n_checks = 0;

    // Free-running 50 MHz clock
    always #10 mclk = ~mclk;

    lsdc_host i_lsdc_host (.i_mclk(mclk), .o_hs_wr(hs_wr),
        .o_hs_data(hs_data), .o_ls_wr(ls_wr), .o_ls_data(ls_data),
        .o_pwm(pwm));

    lsdc_switch_ctrl i_lsdc_switch_ctrl (.i_mclk(mclk), .i_rstn(rstn),
        .i_hs_ctrl_wr(hs_wr), .i_hs_ctrl_data(hs_data),
        .i_ls_ctrl_wr(ls_wr), .i_ls_ctrl_data(ls_data),
        .i_overvoltage_shutdown_enable(ov_en), .i_irq_mask(irq_mask),
        .i_low_power_mode(lpm), .i_pwm_direct_input(pwm),
        .i_high_voltage(hv), .i_hs_sense(hs_sense), .i_ls_sense(ls_sense),
        .o_hs_on(hs_on), .o_ls1_on(ls1_on), .o_ls2_on(ls2_on),
        .o_hs_status(hs_status), .o_ls_status(ls_status),
        .o_irq_source(irq_source), .o_irq_n(irq_n));

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic complete_run();
        if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // PWM gating needs both bits; odd bits ignored; pin lags three edges
    task automatic t_hs_ctrl();
        i_lsdc_host.wr_hs(4'h1); tick(1); `CHK(hs_on, 1'h1)
        i_lsdc_host.wr_hs(4'ha); tick(1); `CHK(hs_on, 1'h0)
        i_lsdc_host.wr_hs(4'h5); tick(1); `CHK(hs_on, 1'h0)
        i_lsdc_host.set_pwm(1'h1); tick(2); `CHK(hs_on, 1'h0)
        tick(1); `CHK(hs_on, 1'h1)
        i_lsdc_host.set_pwm(1'h0); tick(3); `CHK(hs_on, 1'h0)
    endtask

    // Every low-side field value, with the PWM pin low and high
    task automatic t_ls_ctrl();
        logic [3:0] d;
        logic [1:0] e;
        for (int p = 0; p < 2; p++) begin
            i_lsdc_host.set_pwm(p[0]);
            for (int i = 0; i < 16; i++) begin
                d = i[3:0];
                e = {d[1] & (~d[3] | p[0]), d[0] & (~d[2] | p[0])};
                i_lsdc_host.wr_ls(d); tick(3);
                `CHK({ls2_on, ls1_on}, e)
            end
        end
        i_lsdc_host.wr_ls(4'h0);
    endtask

    // Live status flags follow the sense pins
    task automatic t_status();
        for (int i = 0; i < 16; i++) begin
            hs_sense <= {1'h0, i[1:0]};
            ls_sense <= {1'h0, i[3:0]};
            tick(4);
            `CHK(hs_status, i[1:0])
            `CHK(ls_status, i[3:0])
        end
        hs_sense <= 3'h0;
        ls_sense <= 5'h0;
    endtask

    // Thermal latch survives masking, early writes and cooling
    task automatic t_hs_hot();
        irq_mask <= 2'h2;
        i_lsdc_host.wr_hs(4'h1);
        hs_sense.overtemp <= 1'h1; tick(5);
        `CHK({hs_on, hs_status}, 3'h3)
        `CHK({irq_n, irq_source}, {1'h0, ISRC_HS})
        irq_mask <= 2'h0; tick(2);
        `CHK({irq_n, irq_source}, {1'h1, ISRC_NONE})
        i_lsdc_host.wr_hs(4'h1); tick(2); `CHK(hs_on, 1'h0)
        hs_sense.overtemp <= 1'h0; tick(4); `CHK(hs_on, 1'h0)
        irq_mask <= 2'h2; tick(2); `CHK(irq_n, 1'h0)
        i_lsdc_host.wr_hs(4'h1); tick(1);
        `CHK({hs_on, irq_n, irq_source}, {2'h3, ISRC_NONE})
        irq_mask <= 2'h0;
    endtask

    task automatic t_ls_hot();
        irq_mask <= 2'h1;
        i_lsdc_host.wr_ls(4'h3);
        ls_sense.overtemp <= 1'h1; tick(5);
        `CHK({ls2_on, ls1_on}, 2'h0)
        `CHK(ls_status, 4'hf)
        `CHK({irq_n, irq_source}, {1'h0, ISRC_LS})
        ls_sense.overtemp <= 1'h0; tick(4); `CHK(ls1_on, 1'h0)
        i_lsdc_host.wr_ls(4'h3); tick(1);
        `CHK({ls2_on, ls1_on, irq_n}, 3'h7)
        irq_mask <= 2'h0;
    endtask

    // High voltage cuts only when enabled; each side re-armed by its write
    task automatic t_hv();
        i_lsdc_host.wr_hs(4'h1);
        i_lsdc_host.wr_ls(4'h3);
        hv <= 1'h1; tick(5); `CHK({hs_on, ls2_on, ls1_on}, 3'h7)
        ov_en <= 1'h1; tick(4);
        `CHK({hs_on, ls2_on, ls1_on}, 3'h0)
        i_lsdc_host.wr_hs(4'h1); tick(1); `CHK(hs_on, 1'h0)
        hv <= 1'h0; tick(4); `CHK({hs_on, ls1_on}, 2'h0)
        i_lsdc_host.wr_hs(4'h1); tick(1);
        `CHK({hs_on, ls2_on, ls1_on}, 3'h4)
        i_lsdc_host.wr_ls(4'h3); tick(1); `CHK(ls1_on, 1'h1)
        ov_en <= 1'h0;
    endtask

    task automatic t_lpm();
        lpm <= 1'h1; tick(3);
        `CHK({hs_on, ls2_on, ls1_on}, 3'h4)
        lpm <= 1'h0;
        i_lsdc_host.wr_ls(4'h3); tick(1);
        `CHK({hs_on, ls2_on, ls1_on}, 3'h7)
    endtask

    // Mid-run reset drops fields, latches and a pending request
    task automatic t_reset();
        irq_mask <= 2'h2;
        hs_sense.overtemp <= 1'h1; tick(5); `CHK(irq_n, 1'h0)
        rstn <= 1'h0; tick(2);
        `CHK({hs_on, ls1_on, ls2_on, irq_n, irq_source}, 8'h10)
        hs_sense.overtemp <= 1'h0;
        rstn <= 1'h1; tick(3);
        `CHK({hs_on, ls1_on, ls2_on, irq_n, irq_source}, 8'h10)
        irq_mask <= 2'h0;
    endtask

    // Hang guard, far beyond the few hundred cycles the tests take
    initial begin
        #100000;
        n_errors++;
        complete_run();
    end

    // Reset for five cycles, then the scenarios in turn
    initial begin
        mclk = 1'h0;
        rstn = 1'h0;
        {ov_en, lpm, hv} = 3'h0;
        irq_mask = 2'h0;
        hs_sense = 3'h0;
        ls_sense = 5'h0;
        tick(5);
        rstn <= 1'h1;
        `CHK({hs_on, ls1_on, ls2_on, irq_n, irq_source}, 8'h10)
        t_hs_ctrl();
        t_ls_ctrl();
        t_status();
        t_hs_hot();
        t_ls_hot();
        t_hv();
        t_lpm();
        t_reset();
        complete_run();
    end
endmodule

`default_nettype wire
